// ---- logic/clk_sel_pkg.sv ----
// constants, field layout and bus carrier for the clock source select block
// assumes one 20 MHz reference clock and a plain strobe register port
//
// Notes on behaviour
// - two-bit fast source code, resets to internal rc
// - fast source code changes only on slow clock
// - system clock select bit, 0 slow, 1 fast
// - select bit changes if halt clear or code 3
// - slow source bit, 0 slow rc, 1 crystal
// - slow source bit changes only on fast clock
// - fast oscillator halt bit, changes on slow clock or code 3
package clk_sel_pkg;

   ////////////////////////////////////////////////////////////////////////
   // clock and bus widths
   localparam int unsigned REF_CLK_HZ = 20000000; // reference clock rate
   localparam int unsigned ADDR_W = 8;            // register address width
   localparam int unsigned DATA_W = 8;            // register data width

   ////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] CLOCK_SOURCE_CONTROL_ADDR = 8'hd8;

   ////////////////////////////////////////////////////////////////////////
   // field positions inside clock_source_control
   localparam int unsigned FAST_CODE_HI = 7;  // fast_source_code msb
   localparam int unsigned FAST_CODE_LO = 6;  // fast_source_code lsb
   localparam int unsigned SYS_FAST_BIT = 5;  // system_clock_fast_sel
   localparam int unsigned SLOW_SEL_BIT = 4;  // slow_source_sel
   localparam int unsigned HALT_BIT = 3;      // fast_osc_halt
   localparam int unsigned PRESCALE_HI = 2;   // prescaler code msb
   localparam int unsigned PRESCALE_LO = 0;   // prescaler code lsb

   ////////////////////////////////////////////////////////////////////////
   // fast source codes
   typedef enum logic [1:0] {
      FAST_INTERNAL_RC = 2'h0, // internal_fast_rc_osc
      FAST_CRYSTAL = 2'h1,     // fast_crystal_osc on its two pins
      FAST_UNDEFINED = 2'h2,   // no source defined, refused on write
      FAST_EXTERNAL_RC = 2'h3  // external_rc_osc
   } fast_code_t;

   ////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [1:0] FAST_CODE_RST = 2'h0;
   localparam logic SYS_FAST_RST = 1'b0;
   localparam logic SLOW_SEL_RST = 1'b0;
   localparam logic HALT_RST = 1'b0;
   localparam logic [2:0] PRESCALE_RST = 3'h5;
   localparam logic [7:0] READ_IDLE = 8'h00; // unmapped or idle read data

   ////////////////////////////////////////////////////////////////////////
   // register port request, driven by the bus master
   typedef struct packed {
      logic [7:0] addr;  // byte address
      logic [7:0] wdata; // write data
      logic wr;          // one-cycle write strobe
      logic rd;          // one-cycle read strobe
   } reg_req_t;

   // oscillator enables handed to the analogue cells
   typedef struct packed {
      logic internal_fast_rc_osc; // fast internal rc running
      logic fast_crystal_osc;     // fast crystal running
      logic external_rc_osc;      // external rc running
      logic slow_rc_osc;          // slow internal rc running
      logic slow_crystal_osc;     // slow crystal running
   } osc_en_t;

endpackage

// ---- logic/system_clock_source_select.sv ----
// clock source control register and oscillator steering
// assumes register strobes synchronous to i_ref_clk, one strobe at a time
`timescale 1ns/100ps
module system_clock_source_select (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // register port
   input wire clk_sel_pkg::reg_req_t i_req,
   output logic [7:0] o_rdata,
   // clock selection outputs
   output logic [1:0] o_fast_source_code,
   output logic o_system_clock_fast_sel,
   output logic o_slow_source_sel,
   output logic o_fast_osc_halt,
   output logic [2:0] o_prescale_code,
   output logic o_fast_xtal_pins,
   output logic o_slow_xtal_pins,
   // oscillator enables
   output clk_sel_pkg::osc_en_t o_osc_en,
   // refused write indication
   output logic o_write_refused
);

   ////////////////////////////////////////////////////////////////////////
   // state of the block
   typedef struct packed {
      logic [1:0] fast_source_code;   // selected fast oscillator
      logic system_clock_fast_sel;    // system runs on fast clock
      logic slow_source_sel;          // selected slow oscillator
      logic fast_osc_halt;            // fast oscillators stopped
      logic [2:0] prescale;           // system clock prescaler code
      logic [7:0] rdata;              // read data for the next cycle
      logic refused;                  // a field change was refused
   } state_t;

   state_t state;      // registered state
   state_t next_state; // next value of the state

   // decoded register hit, write and read
   logic hit;
   logic wr_hit;
   logic rd_hit;

   // write data split into fields
   logic [1:0] new_code;
   logic new_sys_fast;
   logic new_slow_sel;
   logic new_halt;
   logic [2:0] new_prescale;

   // change conditions, taken from the value before the write, code_legal from the write data
   logic code_may_change;
   logic sys_may_change;
   logic slow_may_change;
   logic halt_may_change;
   logic code_legal;

   // field wants to change and would be refused
   logic code_blocked;
   logic sys_blocked;
   logic slow_blocked;
   logic halt_blocked;

   // current register image for read back
   logic [7:0] reg_image;

   ////////////////////////////////////////////////////////////////////////
   // address decode and field split
   // a miss on the address leaves every field untouched
   always_comb begin
      hit = 1'b0;
      if (i_req.addr == clk_sel_pkg::CLOCK_SOURCE_CONTROL_ADDR) begin
         hit = 1'b1;
      end else begin
         hit = 1'b0;
      end
      wr_hit = hit & i_req.wr;
      rd_hit = hit & i_req.rd;
      new_code = i_req.wdata[clk_sel_pkg::FAST_CODE_HI:
                             clk_sel_pkg::FAST_CODE_LO];
      new_sys_fast = i_req.wdata[clk_sel_pkg::SYS_FAST_BIT];
      new_slow_sel = i_req.wdata[clk_sel_pkg::SLOW_SEL_BIT];
      new_halt = i_req.wdata[clk_sel_pkg::HALT_BIT];
      new_prescale = i_req.wdata[clk_sel_pkg::PRESCALE_HI:
                                 clk_sel_pkg::PRESCALE_LO];
   end

   ////////////////////////////////////////////////////////////////////////
   // change conditions; all but code_legal judged on the old register contents so that
   // one write cannot unlock a field and change it in the same cycle
   always_comb begin
      // fast source may only move while the system sits on slow clock
      code_may_change = ~state.system_clock_fast_sel;
      // switching the system clock needs a running fast source, or the
      // external rc that the halt bit does not stop
      sys_may_change = ~state.fast_osc_halt |
         (state.fast_source_code ==
          clk_sel_pkg::FAST_EXTERNAL_RC);
      // slow source may only move while the system sits on fast clock
      slow_may_change = state.system_clock_fast_sel;
      // halting the fast oscillators is only safe off the fast clock or on the external rc
      halt_may_change = ~state.system_clock_fast_sel |
         (state.fast_source_code ==
          clk_sel_pkg::FAST_EXTERNAL_RC);
      // code 10 names no oscillator and is never taken; refusing it keeps
      // at most one fast oscillator enable active at any time
      code_legal = (new_code != clk_sel_pkg::FAST_UNDEFINED);
   end

   ////////////////////////////////////////////////////////////////////////
   // a field is blocked when a write asks to change it and may not
   always_comb begin
      code_blocked = wr_hit & (new_code != state.fast_source_code) &
         ~(code_may_change & code_legal);
      sys_blocked = wr_hit &
         (new_sys_fast != state.system_clock_fast_sel) & ~sys_may_change;
      slow_blocked = wr_hit &
         (new_slow_sel != state.slow_source_sel) & ~slow_may_change;
      halt_blocked = wr_hit &
         (new_halt != state.fast_osc_halt) & ~halt_may_change;
   end

   ////////////////////////////////////////////////////////////////////////
   // register image as software sees it
   always_comb begin
      reg_image = clk_sel_pkg::READ_IDLE;
      reg_image[clk_sel_pkg::FAST_CODE_HI:clk_sel_pkg::FAST_CODE_LO] =
         state.fast_source_code;
      reg_image[clk_sel_pkg::SYS_FAST_BIT] = state.system_clock_fast_sel;
      reg_image[clk_sel_pkg::SLOW_SEL_BIT] = state.slow_source_sel;
      reg_image[clk_sel_pkg::HALT_BIT] = state.fast_osc_halt;
      reg_image[clk_sel_pkg::PRESCALE_HI:clk_sel_pkg::PRESCALE_LO] =
         state.prescale;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state: each field updates on its own, a refused field simply
   // keeps its value while the rest of the write goes through; the
   // refusal pulse is cleared every cycle, so software never clears it
   always_comb begin
      next_state = state;
      next_state.refused = 1'b0;
      next_state.rdata = clk_sel_pkg::READ_IDLE;
      if (wr_hit) begin
         // fast source select
         if (!code_blocked) begin
            next_state.fast_source_code = new_code;
         end
         // system clock select
         if (!sys_blocked) begin
            next_state.system_clock_fast_sel = new_sys_fast;
         end
         // slow source select
         if (!slow_blocked) begin
            next_state.slow_source_sel = new_slow_sel;
         end
         // fast oscillator halt
         if (!halt_blocked) begin
            next_state.fast_osc_halt = new_halt;
         end
         // prescaler has no guard
         next_state.prescale = new_prescale;
         // flag any refused field for one cycle
         next_state.refused = code_blocked | sys_blocked |
            slow_blocked | halt_blocked;
      end
      // read data appear in the cycle after the strobe only
      if (rd_hit) begin
         next_state.rdata = reg_image;
      end else begin
         next_state.rdata = clk_sel_pkg::READ_IDLE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register; the asynchronous branch loads constants only, so a
   // reset can never capture a half-decoded bus request
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state.fast_source_code <= clk_sel_pkg::FAST_CODE_RST;
         state.system_clock_fast_sel <= clk_sel_pkg::SYS_FAST_RST;
         state.slow_source_sel <= clk_sel_pkg::SLOW_SEL_RST;
         state.fast_osc_halt <= clk_sel_pkg::HALT_RST;
         state.prescale <= clk_sel_pkg::PRESCALE_RST;
         state.rdata <= clk_sel_pkg::READ_IDLE;
         state.refused <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops or simple decodes of them
   always_comb begin
      o_rdata = state.rdata;
      o_fast_source_code = state.fast_source_code;
      o_system_clock_fast_sel = state.system_clock_fast_sel;
      o_slow_source_sel = state.slow_source_sel;
      o_fast_osc_halt = state.fast_osc_halt;
      // limitation: the prescaler code is only stored and shown here, the
      // divider that uses it sits outside this block
      o_prescale_code = state.prescale;
      o_write_refused = state.refused;
      // crystal pins are given over to the oscillator while selected
      o_fast_xtal_pins = (state.fast_source_code ==
                          clk_sel_pkg::FAST_CRYSTAL);
      o_slow_xtal_pins = state.slow_source_sel;
      // only the selected fast oscillator runs; halt stops the internal
      // rc and the crystal but leaves the external rc alone
      o_osc_en.internal_fast_rc_osc = ~state.fast_osc_halt &
         (state.fast_source_code == clk_sel_pkg::FAST_INTERNAL_RC);
      o_osc_en.fast_crystal_osc = ~state.fast_osc_halt &
         (state.fast_source_code == clk_sel_pkg::FAST_CRYSTAL);
      // the external rc circuit is the software's to prepare first
      o_osc_en.external_rc_osc = (state.fast_source_code ==
                                  clk_sel_pkg::FAST_EXTERNAL_RC);
      // slow oscillators follow the slow source bit
      o_osc_en.slow_rc_osc = ~state.slow_source_sel;
      o_osc_en.slow_crystal_osc = state.slow_source_sel;
   end

endmodule

// ---- verif/clk_sel_sva.sv ----
// checker for the clock source control register
// assumes it is bound to system_clock_source_select, one clock domain
`timescale 1ns/100ps
module clk_sel_sva (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   // register port
   input wire clk_sel_pkg::reg_req_t i_req,
   input wire logic [7:0] o_rdata,
   // field outputs
   input wire logic [1:0] o_fast_source_code,
   input wire logic o_system_clock_fast_sel,
   input wire logic o_slow_source_sel,
   input wire logic o_fast_osc_halt,
   input wire logic [2:0] o_prescale_code,
   input wire logic o_fast_xtal_pins,
   input wire logic o_write_refused
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   // strobes aimed at the control register
   wire logic wa = i_req.wr && i_req.addr == 8'hd8;
   wire logic ra = i_req.rd && i_req.addr == 8'hd8;
   wire logic [1:0] fc = o_fast_source_code;
   wire logic sel = o_system_clock_fast_sel;
   // whole register image as software sees it
   wire logic [7:0] img = {fc, sel, o_slow_source_sel, o_fast_osc_halt,
      o_prescale_code};
   ////////////////////////////////////////////////////////////////////////
   code_guard_a: assert property (
      $changed(fc) |-> $past(wa && !sel)) else $error("code moved");
   code_write_a: assert property (
      wa && !sel && i_req.wdata[7:6] != 2'h2 |=> fc == $past(i_req.wdata[7:6]))
      else $error("code not taken");
   sel_write_a: assert property (
      wa && (!o_fast_osc_halt || fc == 2'h3) |=>
      sel == $past(i_req.wdata[5])) else $error("select not taken");
   slow_guard_a: assert property (
      $changed(o_slow_source_sel) |-> $past(wa && sel))
      else $error("slow bit moved");
   slow_write_a: assert property (
      wa && sel |=> o_slow_source_sel == $past(i_req.wdata[4]))
      else $error("slow bit not taken");
   halt_guard_a: assert property (
      $changed(o_fast_osc_halt) |-> $past(wa && (!sel || fc == 2'h3)))
      else $error("halt bit moved");
   read_back_a: assert property (
      ra |=> o_rdata == $past(img)) else $error("read data wrong");
   refuse_flag_a: assert property (
      wa && sel && i_req.wdata[7:6] != fc |=> o_write_refused)
      else $error("refusal not flagged");
   xtal_pins_a: assert property (
      o_fast_xtal_pins == (fc == 2'h1)) else $error("crystal pins wrong");
   sel_guard_a: assert property (
      $changed(sel) |-> $past(wa && (!o_fast_osc_halt || fc == 2'h3)))
      else $error("select moved");
   halt_write_a: assert property (
      wa && (!sel || fc == 2'h3) |=>
      o_fast_osc_halt == $past(i_req.wdata[3]))
      else $error("halt bit not taken");
   quiet_refuse_a: assert property (
      !wa |=> !o_write_refused) else $error("refusal without write");
   // main scenarios reached
   cover property (wa && sel);
   cover property (o_write_refused);
   cover property (wa && fc == 2'h3 && o_fast_osc_halt);
   cover property (ra && sel);
endmodule
bind system_clock_source_select clk_sel_sva clk_sel_sva_i (
   .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
   .o_rdata(o_rdata), .o_fast_source_code(o_fast_source_code),
   .o_system_clock_fast_sel(o_system_clock_fast_sel),
   .o_slow_source_sel(o_slow_source_sel), .o_fast_osc_halt(o_fast_osc_halt),
   .o_prescale_code(o_prescale_code), .o_fast_xtal_pins(o_fast_xtal_pins),
   .o_write_refused(o_write_refused));

// ---- verif/system_clock_source_select_bench.sv ----
// self-checking bench for the clock source control register
// assumes replies one cycle after each strobe, no wait states
`timescale 1ns/100ps
module system_clock_source_select_bench;
   logic i_ref_clk, i_sys_rst;
   clk_sel_pkg::reg_req_t i_req;
   logic [7:0] o_rdata;
   logic [1:0] o_fast_source_code;
   logic [2:0] o_prescale_code;
   logic o_system_clock_fast_sel, o_slow_source_sel, o_fast_osc_halt;
   logic o_fast_xtal_pins, o_slow_xtal_pins, o_write_refused;
   clk_sel_pkg::osc_en_t o_osc_en;
   int error_cnt, checks_done;
   system_clock_source_select system_clock_source_select_i (
      .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req(i_req),
      .o_rdata(o_rdata), .o_fast_source_code(o_fast_source_code),
      .o_system_clock_fast_sel(o_system_clock_fast_sel),
      .o_slow_source_sel(o_slow_source_sel),
      .o_fast_osc_halt(o_fast_osc_halt), .o_prescale_code(o_prescale_code),
      .o_fast_xtal_pins(o_fast_xtal_pins),
      .o_slow_xtal_pins(o_slow_xtal_pins), .o_osc_en(o_osc_en),
      .o_write_refused(o_write_refused));
   ////////////////////////////////////////////////////////////////////////
   // 20 MHz reference clock
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   task automatic chk(input string name, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one-cycle strobes, outputs looked at once the answer edge has landed
   task automatic wr_reg(input logic [7:0] a, d);
      @(posedge i_ref_clk);
      i_req.addr <= a;
      i_req.wdata <= d;
      i_req.wr <= 1'b1;
      @(posedge i_ref_clk);
      i_req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
      @(posedge i_ref_clk);
      i_req.addr <= a;
      i_req.rd <= 1'b1;
      @(posedge i_ref_clk);
      i_req.rd <= 1'b0;
      #1 q = o_rdata;
   endtask
   // write, judge the refusal pulse, then read the image back
   task automatic wck(input logic [7:0] d, img, input logic refd);
      logic [7:0] q;
      wr_reg(8'hd8, d);
      chk("write_refused", {7'h00, o_write_refused}, {7'h00, refd});
      rd_reg(8'hd8, q);
      chk("control_image", q, img);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [7:0] q;
      rd_reg(8'hd8, q);
      chk("reset_image", q, 8'h05);
      chk("osc_enables", {3'h0, o_osc_en}, 8'h12);
      @(posedge i_ref_clk);
      #1 chk("read_idle", o_rdata, 8'h00);
   endtask
   // every fast code in slow mode; external rc taken as prepared
   task automatic t_codes;
      wck(8'h45, 8'h45, 1'b0);
      chk("xtal_pins", {7'h00, o_fast_xtal_pins}, 8'h01);
      chk("osc_enables", {3'h0, o_osc_en}, 8'h0a);
      wck(8'hc5, 8'hc5, 1'b0);
      wck(8'h85, 8'hc5, 1'b1);
      wck(8'h05, 8'h05, 1'b0);
   endtask
   // mode changes against the halt bit and the code 3 escape
   task automatic t_modes;
      wck(8'h0d, 8'h0d, 1'b0);
      wck(8'h2d, 8'h0d, 1'b1);
      wck(8'hcd, 8'hcd, 1'b0);
      wck(8'hed, 8'hed, 1'b0);
      chk("fast_sel", {7'h00, o_system_clock_fast_sel}, 8'h01);
      chk("osc_enables", {3'h0, o_osc_en}, 8'h06);
      wck(8'h3d, 8'hfd, 1'b1);
      chk("slow_xtal_pins", {7'h00, o_slow_xtal_pins}, 8'h01);
      chk("osc_enables", {3'h0, o_osc_en}, 8'h05);
      wck(8'hc4, 8'hc4, 1'b0);
      chk("prescale", {5'h00, o_prescale_code}, 8'h04);
      wck(8'hd4, 8'hc4, 1'b1);
   endtask
   // unmapped place, then a reset in mid-run
   task automatic t_misc;
      logic [7:0] q;
      wr_reg(8'hd9, 8'h3f);
      rd_reg(8'hd9, q);
      chk("unmapped_read", q, 8'h00);
      rd_reg(8'hd8, q);
      chk("after_unmapped", q, 8'hc4);
      // reset raised on an edge and held over two edges
      @(posedge i_ref_clk);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      rd_reg(8'hd8, q);
      chk("rereset_image", q, 8'h05);
      chk("rereset_refused", {7'h00, o_write_refused}, 8'h00);
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // main sequence: reset held 8 cycles, then each scenario
   initial begin
      i_sys_rst = 1'b1;
      i_req = '0;
      error_cnt = 0;
      checks_done = 0;
      repeat (8) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      t_reset;
      t_codes;
      t_modes;
      t_misc;
      finish_test;
   end
   // cuts a hang short
   initial begin
      repeat (5000) @(posedge i_ref_clk);
      error_cnt++;
      finish_test;
   end
endmodule
